//--- common/hcds_cfg.svh
// address map, bit positions, reset values and widths of the dip/swell enable block
`ifndef HCDS_CFG_SVH
`define HCDS_CFG_SVH

// ****************************************************************
// bus geometry
// ****************************************************************
`define HCDS_ADDR_W      16
`define HCDS_DATA_W      32
`define HCDS_NUM_COND    18

// ****************************************************************
// register word indices (byte address = index * 4)
// ****************************************************************
`define HCDS_ENABLE_IDX  14'h0408
`define HCDS_STATUS_IDX  14'h040c
`define HCDS_COND_IDX    14'h040d

// ****************************************************************
// reset values
// ****************************************************************
`define HCDS_ENABLE_RST  18'h00000
`define HCDS_STATUS_RST  18'h00000

// ****************************************************************
// bit positions, shared by enable, status and condition views
// ****************************************************************
`define HCDS_BIT_C_I_SWELL   17
`define HCDS_BIT_C_V_SWELL   16
`define HCDS_BIT_B_I_SWELL   15
`define HCDS_BIT_B_V_SWELL   14
`define HCDS_BIT_A_I_SWELL   13
`define HCDS_BIT_A_V_SWELL   12
`define HCDS_BIT_X5_DIP      11
`define HCDS_BIT_X0_DIP      6
`define HCDS_BIT_C_I_DIP     5
`define HCDS_BIT_C_V_DIP     4
`define HCDS_BIT_B_I_DIP     3
`define HCDS_BIT_B_V_DIP     2
`define HCDS_BIT_A_I_DIP     1
`define HCDS_BIT_A_V_DIP     0

`endif

//--- common/hcds_pkg.sv
// types of the half-cycle dip/swell interrupt enable block
package hcds_pkg;

    // live conditions from the half-cycle rms detectors, one level each
    typedef struct packed {
        logic phase_c_current_overrange;
        logic phase_c_voltage_overrange;
        logic phase_b_current_overrange;
        logic phase_b_voltage_overrange;
        logic phase_a_current_overrange;
        logic phase_a_voltage_overrange;
        logic [5:0] extra_ch_underrange;
        logic phase_c_current_underrange;
        logic phase_c_voltage_underrange;
        logic phase_b_current_underrange;
        logic phase_b_voltage_underrange;
        logic phase_a_current_underrange;
        logic phase_a_voltage_underrange;
    } hcds_cond_t;

    // software enable register, same bit layout as the conditions
    typedef struct packed {
        logic phase_c_current_overrange_half_en;
        logic phase_c_voltage_overrange_half_en;
        logic phase_b_current_overrange_half_en;
        logic phase_b_voltage_overrange_half_en;
        logic phase_a_current_overrange_half_en;
        logic phase_a_voltage_overrange_half_en;
        logic extra_ch5_underrange_half_en;
        logic extra_ch4_underrange_half_en;
        logic extra_ch3_underrange_half_en;
        logic extra_ch2_underrange_half_en;
        logic extra_ch1_underrange_half_en;
        logic extra_ch0_underrange_half_en;
        logic phase_c_current_underrange_half_en;
        logic phase_c_voltage_underrange_half_en;
        logic phase_b_current_underrange_half_en;
        logic phase_b_voltage_underrange_half_en;
        logic phase_a_current_underrange_half_en;
        logic phase_a_voltage_underrange_half_en;
    } hcds_enable_t;

    // which register an apb address hits
    typedef enum logic [1:0] {
        HCDS_SEL_NONE,
        HCDS_SEL_ENABLE,
        HCDS_SEL_STATUS,
        HCDS_SEL_COND
    } hcds_sel_t;

endpackage

//--- src/hcds_irq_top.sv
// half-cycle dip/swell interrupt enable register with apb slave and irq
`timescale 1ns/1ps
`include "hcds_cfg.svh"

module hcds_irq_top
    import hcds_pkg::*;
#(
    parameter int NUM_COND = `HCDS_NUM_COND
) (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [`HCDS_ADDR_W-1:0]  paddr,
    input  wire logic [`HCDS_DATA_W-1:0]  pwdata,
    output logic      [`HCDS_DATA_W-1:0]  prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire hcds_cond_t               cond,
    output logic                          irq
);

    // ****************************************************************
    // elaboration check
    // ****************************************************************
    // the logic maps fields by position, so every layout must agree with NUM_COND
    generate
        if (NUM_COND != $bits(hcds_cond_t)) begin : g_bad_count
            $error("hcds_irq_top: NUM_COND must match the condition layout");
        end
        if (NUM_COND != $bits(hcds_enable_t)) begin : g_bad_enable
            $error("hcds_irq_top: NUM_COND must match the enable layout");
        end
        if (NUM_COND > `HCDS_DATA_W) begin : g_bad_width
            $error("hcds_irq_top: the flags must fit one bus word");
        end
        // six extra channels sit in one contiguous field
        if (`HCDS_BIT_X5_DIP - `HCDS_BIT_X0_DIP != 5) begin : g_bad_extra
            $error("hcds_irq_top: extra channel field must be six bits wide");
        end
        // the bit map must run from the top flag down to bit zero
        if (`HCDS_BIT_C_I_SWELL != NUM_COND - 1) begin : g_bad_top
            $error("hcds_irq_top: top flag must sit at NUM_COND-1");
        end
        if (`HCDS_BIT_A_V_DIP != 0) begin : g_bad_bottom
            $error("hcds_irq_top: bottom flag must sit at bit zero");
        end
    endgenerate

    // ****************************************************************
    // address decode
    // ****************************************************************
    localparam int PAD_W = `HCDS_DATA_W - NUM_COND;

    // map a byte address onto one of the word registers
    function automatic hcds_sel_t hcds_decode(input logic [`HCDS_ADDR_W-1:0] addr);
        logic [`HCDS_ADDR_W-3:0] idx;
        idx = addr[`HCDS_ADDR_W-1:2];
        if (idx == `HCDS_ENABLE_IDX) begin
            return HCDS_SEL_ENABLE;
        end else if (idx == `HCDS_STATUS_IDX) begin
            return HCDS_SEL_STATUS;
        end else if (idx == `HCDS_COND_IDX) begin
            return HCDS_SEL_COND;
        end else begin
            return HCDS_SEL_NONE;
        end
    endfunction

    // widen a flag view to a bus word; reserved upper bits read as zero
    function automatic logic [`HCDS_DATA_W-1:0] hcds_pad(input logic [NUM_COND-1:0] v);
        return {{PAD_W{1'b0}}, v};
    endfunction

    hcds_sel_t            sel;
    logic                 hit_enable;
    logic                 hit_status;
    logic                 hit_cond;
    logic                 hit_none;
    logic                 setup_ph;
    logic                 access_ph;
    logic                 wr_enable;
    logic                 wr_status;

    // low two address bits are ignored; apb3 has no byte strobes
    assign sel        = hcds_decode(paddr);
    assign hit_enable = (sel == HCDS_SEL_ENABLE);
    assign hit_status = (sel == HCDS_SEL_STATUS);
    assign hit_cond   = (sel == HCDS_SEL_COND);
    assign hit_none   = (sel == HCDS_SEL_NONE);

    // apb phases, from the two strobes alone
    assign setup_ph   = psel & ~penable;
    assign access_ph  = psel & penable;

    // only enable and status have a write strobe; the condition view and
    // unmapped words drop a write without any side effect
    assign wr_enable  = access_ph & pwrite & hit_enable;
    assign wr_status  = access_ph & pwrite & hit_status;

    // zero wait states; unmapped words answer with an error
    assign pready     = 1'b1;
    assign pslverr    = access_ph & hit_none;

    // ****************************************************************
    // condition inputs
    // ****************************************************************
    // detectors run on pclk, so the levels are used without synchronising
    logic [NUM_COND-1:0] cond_vec;

    // each level is high only while the half-cycle rms result is out of range
    assign cond_vec[`HCDS_BIT_C_I_SWELL] = cond.phase_c_current_overrange;
    assign cond_vec[`HCDS_BIT_B_I_SWELL] = cond.phase_b_current_overrange;
    assign cond_vec[`HCDS_BIT_A_I_SWELL] = cond.phase_a_current_overrange;
    assign cond_vec[`HCDS_BIT_C_V_SWELL] = cond.phase_c_voltage_overrange;
    assign cond_vec[`HCDS_BIT_B_V_SWELL] = cond.phase_b_voltage_overrange;
    assign cond_vec[`HCDS_BIT_A_V_SWELL] = cond.phase_a_voltage_overrange;
    // extra channel 5 at the top down to channel 0 at the bottom
    assign cond_vec[`HCDS_BIT_X5_DIP:`HCDS_BIT_X0_DIP] = cond.extra_ch_underrange;
    assign cond_vec[`HCDS_BIT_C_I_DIP] = cond.phase_c_current_underrange;
    assign cond_vec[`HCDS_BIT_B_I_DIP] = cond.phase_b_current_underrange;
    assign cond_vec[`HCDS_BIT_C_V_DIP] = cond.phase_c_voltage_underrange;
    assign cond_vec[`HCDS_BIT_B_V_DIP] = cond.phase_b_voltage_underrange;
    assign cond_vec[`HCDS_BIT_A_I_DIP] = cond.phase_a_current_underrange;
    assign cond_vec[`HCDS_BIT_A_V_DIP] = cond.phase_a_voltage_underrange;

    // ****************************************************************
    // enable register
    // ****************************************************************
    hcds_enable_t         enable_q;
    hcds_enable_t         enable_d;
    logic [NUM_COND-1:0]  enable_vec;

    // field order of the struct is the bit order of the word
    assign enable_d   = wr_enable ? hcds_enable_t'(pwdata[NUM_COND-1:0]) : enable_q;
    assign enable_vec = enable_q;

    // all enables off after reset so nothing fires before software asks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_q <= hcds_enable_t'(`HCDS_ENABLE_RST);
        end else begin
            enable_q <= enable_d;
        end
    end

    // ****************************************************************
    // sticky status and interrupt
    // ****************************************************************
    logic [NUM_COND-1:0]  status_q;
    logic [NUM_COND-1:0]  status_clr;
    logic [NUM_COND-1:0]  status_nxt;
    logic [NUM_COND-1:0]  pending_d;

    // write one to clear; a condition still present sets the bit again, so
    // software has to wait for the condition to end before a clear sticks
    assign status_clr = wr_status ? pwdata[NUM_COND-1:0] : '0;

    hcds_sticky_flags #(
        .W       (NUM_COND)
    ) u_status (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (cond_vec),
        .clear   (status_clr),
        .flags_q (status_q)
    );

    // status as it stands after this edge: the clear first, then new events
    assign status_nxt = (status_q & ~status_clr) | cond_vec;

    // only an enabled bit whose condition was seen can request service; the
    // next values keep irq in step with the registers on the same edge
    assign pending_d  = status_nxt & enable_d;

    // irq is a level; registered to keep the pin free of glitches
    logic irq_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |pending_d;
        end
    end

    assign irq = irq_q;

    // ****************************************************************
    // read data
    // ****************************************************************
    logic [`HCDS_DATA_W-1:0] rd_mux;
    logic [`HCDS_DATA_W-1:0] prdata_q;
    logic [`HCDS_DATA_W-1:0] prdata_d;

    // one view per mapped word; unmapped words read as zero
    assign rd_mux = hit_enable ? hcds_pad(enable_vec) :
                    hit_status ? hcds_pad(status_q)   :
                    hit_cond   ? hcds_pad(cond_vec)   : '0;

    // a read is captured in its setup cycle so the access cycle sees a stable
    // word; one flop stage buys a prdata free of decode glitches
    logic rd_setup;
    assign rd_setup = setup_ph & ~pwrite;
    assign prdata_d = rd_setup ? rd_mux : prdata_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
        end else begin
            prdata_q <= prdata_d;
        end
    end

    assign prdata = prdata_q;

endmodule

//--- src/hcds_sticky_flags.sv
// sticky event flags with write-one-to-clear, set wins over clear
`timescale 1ns/1ps
`include "hcds_cfg.svh"

module hcds_sticky_flags
    import hcds_pkg::*;
#(
    parameter int W = `HCDS_NUM_COND
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clear,
    output logic      [W-1:0] flags_q
);

    // ****************************************************************
    // elaboration check
    // ****************************************************************
    generate
        if (W < 1 || W > `HCDS_DATA_W) begin : g_bad_w
            $error("hcds_sticky_flags: width must be 1 to 32");
        end
    endgenerate

    // ****************************************************************
    // flag storage
    // ****************************************************************
    logic [W-1:0] flags_d;

    // an event in the clearing cycle survives: set is or-ed in last
    assign flags_d = (flags_q & ~clear) | set;

    // flags start empty after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end

endmodule

//--- verification/hcds_irq_props.sv
// concurrent checks on the ports of the dip/swell interrupt enable block
`timescale 1ns/1ps
`include "hcds_cfg.svh"

module hcds_irq_props
    import hcds_pkg::*;
#(
    parameter int NUM_COND = `HCDS_NUM_COND
) (
    input wire logic                    pclk,
    input wire logic                    presetn,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [`HCDS_ADDR_W-1:0] paddr,
    input wire logic [`HCDS_DATA_W-1:0] pwdata,
    input wire logic [`HCDS_DATA_W-1:0] prdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    input wire hcds_cond_t              cond,
    input wire logic                    irq
);
    // ****************************************************************
    // shadow enable and status, rebuilt from bus traffic and the live cond input
    // ****************************************************************
    logic [NUM_COND-1:0] en_q;
    logic [NUM_COND-1:0] st_q;
    logic [NUM_COND-1:0] en_d;
    logic [NUM_COND-1:0] st_d;
    wire        wr_acc = psel && penable && pwrite && pready;
    wire [13:0] idx    = paddr[15:2];
    wire        mapped = idx inside {`HCDS_ENABLE_IDX, `HCDS_STATUS_IDX, `HCDS_COND_IDX};
    wire        pend_d = |(st_d & en_d);

    // set beats clear, so the live condition is ored in after the clear
    assign en_d = (wr_acc && idx == `HCDS_ENABLE_IDX) ? pwdata[NUM_COND-1:0] : en_q;
    assign st_d = (st_q & ~((wr_acc && idx == `HCDS_STATUS_IDX) ? pwdata[NUM_COND-1:0] : '0))
                | cond;

    // shadow registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= '0;
            st_q <= '0;
        end else begin
            en_q <= en_d;
            st_q <= st_d;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ****************************************************************
    // properties
    // ****************************************************************
    swell_cur_a: assert property (|(cond & en_d & 18'h2a000) |=> irq)
        else $error("current swell did not raise irq");
    swell_volt_a: assert property (|(cond & en_d & 18'h15000) |=> irq)
        else $error("voltage swell did not raise irq");
    extra_dip_a: assert property (|(cond & en_d & 18'h00fc0) |=> irq)
        else $error("extra channel dip did not raise irq");
    dip_cur_a: assert property (|(cond & en_d & 18'h00028) |=> irq)
        else $error("current dip did not raise irq");
    dip_volt_a: assert property (|(cond & en_d & 18'h00014) |=> irq)
        else $error("voltage dip did not raise irq");
    phase_a_dip_a: assert property (|(cond & en_d & 18'h00003) |=> irq)
        else $error("phase a dip did not raise irq");
    irq_exact_a: assert property (1'b1 |=> irq == $past(pend_d))
        else $error("irq differs from stored and enabled conditions");
    no_enable_a: assert property (en_d == '0 |=> !irq)
        else $error("irq with every enable clear");
    slave_err_a: assert property (psel && penable |-> pslverr == !mapped && pready)
        else $error("pslverr does not match address map");

    cover property (wr_acc && idx == `HCDS_ENABLE_IDX);
    cover property ($rose(irq));
    cover property (psel && penable && pslverr);
endmodule

bind hcds_irq_top hcds_irq_props #(.NUM_COND(NUM_COND)) i_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cond(cond), .irq(irq));

//--- verification/test_half_cycle_dip_swell_irq_mask.sv
// self-checking bench for the dip/swell interrupt enable block
`timescale 1ns/1ps
`include "hcds_cfg.svh"

module test_half_cycle_dip_swell_irq_mask
    import hcds_pkg::*;
;
    localparam logic [15:0] A_EN = {`HCDS_ENABLE_IDX, 2'b00};
    localparam logic [15:0] A_ST = {`HCDS_STATUS_IDX, 2'b00};
    localparam logic [15:0] A_CO = {`HCDS_COND_IDX, 2'b00};

    logic                    pclk = 1'b0;
    logic                    presetn = 1'b0;
    logic                    psel = 1'b0;
    logic                    penable = 1'b0;
    logic                    pwrite = 1'b0;
    logic [`HCDS_ADDR_W-1:0] paddr = '0;
    logic [`HCDS_DATA_W-1:0] pwdata = '0;
    logic [`HCDS_DATA_W-1:0] prdata;
    logic                    pready;
    logic                    pslverr;
    hcds_cond_t              cond = '0;
    logic                    irq;
    logic [31:0]             rd;
    logic                    err;
    logic [31:0]             m;
    int                      n_errors = 0;
    int                      total_checks = 0;

    hcds_irq_top #(.NUM_COND(`HCDS_NUM_COND)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cond(cond), .irq(irq));

    // 100 MHz clock
    always #5 pclk = ~pclk;

    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            n_errors++;
        end
    endtask

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            chk("pready", 1, 0);
            end_of_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // one-cycle condition pulse, irq looked at one edge later
    task automatic pulse(input logic [31:0] v, input logic exp);
        @(posedge pclk) cond <= hcds_cond_t'(v[17:0]);
        @(posedge pclk) cond <= '0;
        @(negedge pclk) chk("irq after pulse", {31'h0, exp}, {31'h0, irq});
    endtask

    // write-one-to-clear, then irq and status must both be gone
    task automatic clear(input logic [31:0] v);
        apb(1'b1, A_ST, v);
        repeat (2) @(posedge pclk);
        @(negedge pclk) chk("irq after clear", 0, {31'h0, irq});
        apb(1'b0, A_ST, 0);
        chk("status after clear", 0, rd);
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, A_EN, 0);
        chk("enable reset", 0, rd);
        apb(1'b0, A_ST, 0);
        chk("status reset", 0, rd);
        apb(1'b1, A_EN, 32'hffffffff);
        apb(1'b0, A_EN, 0);
        chk("enable rw", 32'h0003ffff, rd);
        $display("test reset and access done");
        // every enable bit against its own condition bit
        for (int i = 0; i < 18; i++) begin
            m = 32'h1 << i;
            apb(1'b1, A_EN, ~m & 32'h3ffff);
            pulse(m, 1'b0);
            apb(1'b0, A_ST, 0);
            chk("stored status", m, rd);
            apb(1'b1, A_EN, m);
            @(negedge pclk) chk("irq on enable", 1, {31'h0, irq});
            clear(m);
            pulse(m, 1'b1);
            clear(m);
        end
        $display("test bit map done");
        cond <= hcds_cond_t'(18'h2a5c3);
        apb(1'b1, A_CO, 0);
        chk("cond write err", 0, {31'h0, err});
        apb(1'b0, A_CO, 0);
        chk("cond live", 32'h0002a5c3, rd);
        cond <= '0;
        clear(32'h3ffff);
        apb(1'b0, 16'h0000, 0);
        chk("unmapped err", 1, {31'h0, err});
        chk("unmapped data", 0, rd);
        apb(1'b1, 16'h0000, 32'hffffffff);
        chk("unmapped wr err", 1, {31'h0, err});
        apb(1'b0, A_EN, 0);
        chk("enable kept", 32'h00020000, rd);
        $display("test cond and unmapped done");
        // a reset in mid-run brings enables, status and irq back to zero
        apb(1'b1, A_EN, 32'h0003ffff);
        pulse(32'h1, 1'b1);
        @(posedge pclk) presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        @(negedge pclk) chk("irq in reset", 0, {31'h0, irq});
        @(posedge pclk) presetn <= 1'b1;
        apb(1'b0, A_EN, 0);
        chk("enable after reset", 0, rd);
        apb(1'b0, A_ST, 0);
        chk("status after reset", 0, rd);
        $display("test mid-run reset done");
        end_of_test();
    end
endmodule
